// ==== logic/pgdp_pkg.sv ====
// Shared constants for the planar graphics datapath
package pgdp_pkg;
	localparam logic [15:0] PGDP_PORT_INDEX = 16'h03CE;
	localparam logic [15:0] PGDP_PORT_DATA = 16'h03CF;
	localparam logic [3:0] PGDP_IDX_FILL_VALUE = 4'h0;
	localparam logic [3:0] PGDP_IDX_FILL_ENABLE = 4'h1;
	localparam logic [3:0] PGDP_IDX_COMPARE = 4'h2;
	localparam logic [3:0] PGDP_IDX_ROTATE = 4'h3;
	localparam logic [3:0] PGDP_IDX_READ_PLANE = 4'h4;
	localparam logic [3:0] PGDP_IDX_MODE = 4'h5;
	localparam logic [3:0] PGDP_IDX_MISC = 4'h6;
	localparam logic [3:0] PGDP_IDX_IGNORE = 4'h7;
	localparam logic [3:0] PGDP_IDX_BIT_MASK = 4'h8;
	localparam logic [7:0] PGDP_RST_REG = 8'h00;
	localparam logic [7:0] PGDP_RST_BIT_MASK = 8'hFF;
	localparam logic [7:0] PGDP_RST_IGNORE = 8'h0F;
	localparam int PGDP_ROT_LSB = 0;
	localparam int PGDP_FUNC_LSB = 3;
	localparam int PGDP_WMODE_LSB = 0;
	localparam int PGDP_RMODE_BIT = 3;
	localparam int PGDP_ODDEVEN_BIT = 4;
	localparam int PGDP_SHIFT_BIT = 5;
	localparam int PGDP_SHIFT256_BIT = 6;
	localparam int PGDP_GFX_BIT = 0;
	localparam int PGDP_CHAIN_OE_BIT = 1;
	localparam int PGDP_MAP_LSB = 2;
	localparam int PGDP_CHAIN4_BIT = 3;
	localparam int PGDP_SEQ_OE_BIT = 2;
	localparam logic [19:0] PGDP_WIN_A000 = 20'hA0000;
	localparam logic [19:0] PGDP_WIN_B000 = 20'hB0000;
	localparam logic [19:0] PGDP_WIN_B800 = 20'hB8000;
	localparam logic [19:0] PGDP_LEN_128K = 20'h20000;
	localparam logic [19:0] PGDP_LEN_64K = 20'h10000;
	localparam logic [19:0] PGDP_LEN_32K = 20'h08000;
	typedef enum logic [2:0] {
		PGDP_ST_IDLE = 3'b001,
		PGDP_ST_READ = 3'b010,
		PGDP_ST_DONE = 3'b100
	} pgdp_state_t;
endpackage

// ==== logic/pgdp_regfile.sv ====
// Indexed graphics register storage with registered read data
`timescale 1ns/1ps
module pgdp_regfile
	import pgdp_pkg::*;
(
	input wire logic clk_sys_i,
	input wire logic rst_i,
	input wire logic wr_i,
	input wire logic [3:0] idx_i,
	input wire logic [7:0] wdata_i,
	output logic [7:0] rdata_o,
	output logic [8:0][7:0] regs_o
);
	logic [8:0][7:0] mem_r;
	assign regs_o = mem_r;

	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			for (int i = 0; i < 9; i++) begin
				mem_r[i] <= PGDP_RST_REG;
			end
			mem_r[PGDP_IDX_IGNORE] <= PGDP_RST_IGNORE;
			mem_r[PGDP_IDX_BIT_MASK] <= PGDP_RST_BIT_MASK;
		end else if (wr_i && idx_i <= PGDP_IDX_BIT_MASK) begin
			mem_r[idx_i] <= wdata_i;
		end
	end

	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			rdata_o <= 8'h00;
		end else if (idx_i <= PGDP_IDX_BIT_MASK) begin
			rdata_o <= mem_r[idx_i];
		end else begin
			rdata_o <= 8'h00;
		end
	end
endmodule

// ==== logic/pgdp_write_unit.sv ====
// Combinational write-data path for all four planes
`timescale 1ns/1ps
module pgdp_write_unit
	import pgdp_pkg::*;
(
	input wire logic [1:0] wmode_i,
	input wire logic [7:0] cpu_data_i,
	input wire logic [2:0] rot_i,
	input wire logic [1:0] func_i,
	input wire logic [3:0] fill_value_i,
	input wire logic [3:0] fill_enable_i,
	input wire logic [7:0] bit_mask_i,
	input wire logic [3:0][7:0] latch_i,
	output logic [3:0][7:0] plane_data_o
);
	function automatic logic [7:0] pgdp_ror(input logic [7:0] d,
		input logic [2:0] n);
		logic [15:0] t;
		t = {d, d} >> n;
		return t[7:0];
	endfunction

	logic [7:0] rot_data;
	logic [7:0] eff_mask;
	logic [3:0] fill_sel;
	logic [3:0][7:0] mode_data;
	logic [3:0][7:0] func_data;

	assign rot_data = pgdp_ror(cpu_data_i, rot_i);
	assign eff_mask = (wmode_i == 2'd3) ? (rot_data & bit_mask_i)
		: bit_mask_i;
	assign fill_sel = (wmode_i == 2'd3) ? 4'hF : fill_enable_i;

	always_comb begin
		for (int p = 0; p < 4; p++) begin
			case (wmode_i)
				2'd0: mode_data[p] = fill_sel[p] ? {8{fill_value_i[p]}}
					: rot_data;
				2'd1: mode_data[p] = latch_i[p];
				2'd2: mode_data[p] = {8{cpu_data_i[p]}};
				default: mode_data[p] = {8{fill_value_i[p]}};
			endcase
			case (func_i)
				2'd1: func_data[p] = mode_data[p] & latch_i[p];
				2'd2: func_data[p] = mode_data[p] | latch_i[p];
				2'd3: func_data[p] = mode_data[p] ^ latch_i[p];
				default: func_data[p] = mode_data[p];
			endcase
			if (wmode_i == 2'd1) begin
				func_data[p] = mode_data[p];
			end
			plane_data_o[p] = (func_data[p] & eff_mask)
				| (latch_i[p] & ~eff_mask);
		end
	end
endmodule

// ==== logic/pgdp_top.sv ====
// Planar graphics datapath: register ports, plane access, compare
`timescale 1ns/1ps
module pgdp_top
	import pgdp_pkg::*;
(
	input wire logic clk_sys_i,
	input wire logic rst_i,
	input wire logic io_wr_i,
	input wire logic io_rd_i,
	input wire logic [15:0] io_addr_i,
	input wire logic [7:0] io_wdata_i,
	output logic [7:0] io_rdata_o,
	output logic io_hit_o,
	input wire logic mem_wr_i,
	input wire logic mem_rd_i,
	input wire logic [19:0] mem_addr_i,
	input wire logic [7:0] mem_wdata_i,
	output logic [7:0] mem_rdata_o,
	output logic mem_hit_o,
	output logic mem_rvalid_o,
	input wire logic [3:0] plane_write_mask_i,
	input wire logic [7:0] memory_organization_i,
	output logic [15:0] plane_addr_o,
	output logic [3:0] plane_we_o,
	output logic [3:0] plane_re_o,
	output logic [3:0][7:0] plane_wdata_o,
	input wire logic [3:0][7:0] plane_rdata_i,
	output logic shift_256_o,
	output logic shift_interleave_o,
	output logic graphics_mode_o,
	output logic char_latch_en_o
);
	////////////////////////////////////////////////////////////////
	// Register ports
	logic [7:0] graphics_index_pointer_r;
	logic [8:0][7:0] regs;
	logic [7:0] reg_rdata;
	logic idx_sel;
	logic dat_sel;
	logic dat_rd_r;
	logic idx_rd_r;

	assign idx_sel = (io_addr_i == PGDP_PORT_INDEX);
	assign dat_sel = (io_addr_i == PGDP_PORT_DATA);
	assign io_hit_o = idx_sel | dat_sel;

	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			graphics_index_pointer_r <= PGDP_RST_REG;
			dat_rd_r <= 1'b0;
			idx_rd_r <= 1'b0;
		end else begin
			if (io_wr_i && idx_sel) begin
				graphics_index_pointer_r <= io_wdata_i;
			end
			dat_rd_r <= io_rd_i & dat_sel;
			idx_rd_r <= io_rd_i & idx_sel;
		end
	end

	logic [7:0] io_rdata_r;
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			io_rdata_r <= 8'h00;
		end else if (io_rd_i && idx_sel) begin
			io_rdata_r <= graphics_index_pointer_r;
		end
	end
	assign io_rdata_o = dat_rd_r ? reg_rdata
		: (idx_rd_r ? io_rdata_r : 8'h00);

	pgdp_regfile u_regs (
		.clk_sys_i(clk_sys_i),
		.rst_i(rst_i),
		.wr_i(io_wr_i & dat_sel),
		.idx_i(graphics_index_pointer_r[3:0]),
		.wdata_i(io_wdata_i),
		.rdata_o(reg_rdata),
		.regs_o(regs)
	);

	////////////////////////////////////////////////////////////////
	// Register fields
	logic [7:0] fill_value_reg;
	logic [7:0] fill_enable_reg;
	logic [7:0] compare_value_reg;
	logic [7:0] rotate_logic_reg;
	logic [7:0] read_plane_select_reg;
	logic [7:0] graphics_mode_reg;
	logic [7:0] misc_map_reg;
	logic [7:0] compare_ignore_reg;
	logic [7:0] write_bit_mask_reg;
	assign fill_value_reg = regs[PGDP_IDX_FILL_VALUE];
	assign fill_enable_reg = regs[PGDP_IDX_FILL_ENABLE];
	assign compare_value_reg = regs[PGDP_IDX_COMPARE];
	assign rotate_logic_reg = regs[PGDP_IDX_ROTATE];
	assign read_plane_select_reg = regs[PGDP_IDX_READ_PLANE];
	assign graphics_mode_reg = regs[PGDP_IDX_MODE];
	assign misc_map_reg = regs[PGDP_IDX_MISC];
	assign compare_ignore_reg = regs[PGDP_IDX_IGNORE];
	assign write_bit_mask_reg = regs[PGDP_IDX_BIT_MASK];

	logic chain4;
	logic odd_even;
	logic chain_odd;
	logic read_cmp;
	assign chain4 = memory_organization_i[PGDP_CHAIN4_BIT];
	assign odd_even = graphics_mode_reg[PGDP_ODDEVEN_BIT]
		| ~memory_organization_i[PGDP_SEQ_OE_BIT];
	assign chain_odd = misc_map_reg[PGDP_CHAIN_OE_BIT];
	assign read_cmp = graphics_mode_reg[PGDP_RMODE_BIT];

	////////////////////////////////////////////////////////////////
	// Shift register and graphics mode outputs
	assign shift_256_o = graphics_mode_reg[PGDP_SHIFT256_BIT];
	assign shift_interleave_o = ~graphics_mode_reg[PGDP_SHIFT256_BIT]
		& graphics_mode_reg[PGDP_SHIFT_BIT];
	assign graphics_mode_o = misc_map_reg[PGDP_GFX_BIT];
	assign char_latch_en_o = ~misc_map_reg[PGDP_GFX_BIT];

	////////////////////////////////////////////////////////////////
	// Host window decode
	logic [19:0] win_base;
	logic [19:0] win_len;
	logic [19:0] win_off;
	logic [1:0] map_sel;
	assign map_sel = misc_map_reg[PGDP_MAP_LSB +: 2];
	assign win_base = (map_sel == 2'd2) ? PGDP_WIN_B000
		: (map_sel == 2'd3) ? PGDP_WIN_B800 : PGDP_WIN_A000;
	assign win_len = (map_sel == 2'd0) ? PGDP_LEN_128K
		: (map_sel == 2'd1) ? PGDP_LEN_64K : PGDP_LEN_32K;
	assign win_off = mem_addr_i - win_base;
	assign mem_hit_o = (mem_addr_i >= win_base) && (win_off < win_len);

	////////////////////////////////////////////////////////////////
	// Plane addressing and selection
	logic [15:0] acc_addr;
	logic [3:0] plane_sel;
	logic [1:0] rd_plane;

	function automatic logic [3:0] pgdp_pair_sel(input logic a0);
		return a0 ? 4'b1010 : 4'b0101;
	endfunction

	always_comb begin
		if (chain4) begin
			acc_addr = {2'b00, win_off[15:2]};
			plane_sel = 4'b0001 << win_off[1:0];
		end else if (chain_odd) begin
			acc_addr = {win_off[15:1], win_off[16]};
			plane_sel = pgdp_pair_sel(win_off[0]);
		end else if (odd_even) begin
			acc_addr = {1'b0, win_off[15:1]};
			plane_sel = pgdp_pair_sel(win_off[0]);
		end else begin
			acc_addr = win_off[15:0];
			plane_sel = 4'b1111;
		end
	end

	assign rd_plane = chain4 ? win_off[1:0]
		: (odd_even | chain_odd)
		? {read_plane_select_reg[1], win_off[0]}
		: read_plane_select_reg[1:0];

	////////////////////////////////////////////////////////////////
	// Access sequencer and CPU latches
	pgdp_state_t state_r;
	pgdp_state_t state_nxt;
	logic [3:0][7:0] latch_r;
	logic [1:0] rd_plane_r;
	logic [15:0] plane_addr_r;
	logic rd_go;
	logic wr_go;
	assign rd_go = mem_rd_i & mem_hit_o & (state_r == PGDP_ST_IDLE);
	assign wr_go = mem_wr_i & mem_hit_o & (state_r == PGDP_ST_IDLE);

	always_comb begin
		state_nxt = state_r;
		case (state_r)
			PGDP_ST_IDLE: if (rd_go) state_nxt = PGDP_ST_READ;
			PGDP_ST_READ: state_nxt = PGDP_ST_DONE;
			PGDP_ST_DONE: state_nxt = PGDP_ST_IDLE;
			default: state_nxt = PGDP_ST_IDLE;
		endcase
	end

	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			state_r <= PGDP_ST_IDLE;
			plane_addr_r <= 16'h0000;
			rd_plane_r <= 2'b00;
		end else begin
			state_r <= state_nxt;
			if (rd_go || wr_go) begin
				plane_addr_r <= acc_addr;
				rd_plane_r <= rd_plane;
			end
		end
	end
	assign plane_addr_o = (rd_go || wr_go) ? acc_addr : plane_addr_r;

	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			latch_r <= '0;
		end else if (state_r == PGDP_ST_READ) begin
			latch_r <= plane_rdata_i;
		end
	end

	////////////////////////////////////////////////////////////////
	// Read path
	logic [7:0] cmp_bits;
	logic [7:0] rd_byte;
	always_comb begin
		for (int b = 0; b < 8; b++) begin
			cmp_bits[b] = 1'b1;
			for (int p = 0; p < 4; p++) begin
				if (compare_ignore_reg[p] &&
					plane_rdata_i[p][b] != compare_value_reg[p]) begin
					cmp_bits[b] = 1'b0;
				end
			end
		end
	end
	assign rd_byte = read_cmp ? cmp_bits : plane_rdata_i[rd_plane_r];

	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			mem_rdata_o <= 8'h00;
			mem_rvalid_o <= 1'b0;
		end else begin
			mem_rvalid_o <= (state_r == PGDP_ST_READ);
			if (state_r == PGDP_ST_READ) begin
				mem_rdata_o <= rd_byte;
			end
		end
	end

	////////////////////////////////////////////////////////////////
	// Write path
	pgdp_write_unit u_wr (
		.wmode_i(graphics_mode_reg[PGDP_WMODE_LSB +: 2]),
		.cpu_data_i(mem_wdata_i),
		.rot_i(rotate_logic_reg[PGDP_ROT_LSB +: 3]),
		.func_i(rotate_logic_reg[PGDP_FUNC_LSB +: 2]),
		.fill_value_i(fill_value_reg[3:0]),
		.fill_enable_i(fill_enable_reg[3:0]),
		.bit_mask_i(write_bit_mask_reg),
		.latch_i(latch_r),
		.plane_data_o(plane_wdata_o)
	);
	assign plane_we_o = wr_go ? (plane_sel & plane_write_mask_i) : 4'h0;
	assign plane_re_o = rd_go ? 4'hF : 4'h0;

	////////////////////////////////////////////////////////////////
	// Checks
	sequence pgdp_rd_busy_s;
		(state_r == PGDP_ST_READ) ##1 (state_r == PGDP_ST_DONE)
			##1 (state_r == PGDP_ST_IDLE);
	endsequence
	sequence pgdp_rd_pulse_s;
		!mem_rvalid_o ##1 mem_rvalid_o ##1 !mem_rvalid_o;
	endsequence

	chk_latch_load: assert property (
		@(posedge clk_sys_i) disable iff (rst_i)
		rd_go |-> ##2 latch_r == $past(plane_rdata_i, 1))
		else $error("latches not loaded by read");
	chk_write_mask: assert property (
		@(posedge clk_sys_i) disable iff (rst_i)
		(plane_we_o & ~plane_write_mask_i) == 4'h0)
		else $error("write reached masked plane");
	chk_chain_read: assert property (
		@(posedge clk_sys_i) disable iff (rst_i)
		rd_go && chain4 |=> rd_plane_r == $past(win_off[1:0]))
		else $error("chain four read plane wrong");
	chk_read_valid: assert property (
		@(posedge clk_sys_i) disable iff (rst_i)
		rd_go |-> ##2 mem_rvalid_o)
		else $error("read answer missing");
	chk_read_busy: assert property (
		@(posedge clk_sys_i) disable iff (rst_i)
		rd_go |=> pgdp_rd_busy_s)
		else $error("read sequencer steps wrong");
	chk_read_pulse: assert property (
		@(posedge clk_sys_i) disable iff (rst_i)
		rd_go |=> pgdp_rd_pulse_s)
		else $error("read valid not a single pulse");
	chk_busy_refuse: assert property (
		@(posedge clk_sys_i) disable iff (rst_i)
		state_r != PGDP_ST_IDLE |-> (plane_we_o | plane_re_o) == 4'h0)
		else $error("plane access while busy");
	chk_chain_write: assert property (
		@(posedge clk_sys_i) disable iff (rst_i)
		wr_go && chain4 |-> plane_we_o
			== ((4'b0001 << mem_addr_i[1:0]) & plane_write_mask_i))
		else $error("chain four write plane wrong");
	chk_odd_addr: assert property (
		@(posedge clk_sys_i) disable iff (rst_i)
		wr_go && chain_odd && !chain4
			|-> plane_addr_o == {win_off[15:1], win_off[16]})
		else $error("chain odd address wrong");
	chk_index_port: assert property (
		@(posedge clk_sys_i) disable iff (rst_i)
		io_wr_i && dat_sel
			&& graphics_index_pointer_r[3:0] == PGDP_IDX_MODE
			|=> graphics_mode_reg == $past(io_wdata_i))
		else $error("data port missed mode register");
	chk_map_64k: assert property (
		@(posedge clk_sys_i) disable iff (rst_i)
		mem_hit_o && map_sel == 2'd1 |-> mem_addr_i[19:16] == 4'hA)
		else $error("64K window hit outside its range");
	chk_mode1_latch: assert property (
		@(posedge clk_sys_i) disable iff (rst_i)
		wr_go && graphics_mode_reg[PGDP_WMODE_LSB +: 2] == 2'd1
			&& write_bit_mask_reg == 8'hFF |-> plane_wdata_o == latch_r)
		else $error("write mode 1 data not from latches");
	chk_mode2_fill: assert property (
		@(posedge clk_sys_i) disable iff (rst_i)
		wr_go && graphics_mode_reg[PGDP_WMODE_LSB +: 2] == 2'd2
			&& rotate_logic_reg[PGDP_FUNC_LSB +: 2] == 2'd0
			&& write_bit_mask_reg == 8'hFF
			|-> plane_wdata_o[0] == {8{mem_wdata_i[0]}})
		else $error("write mode 2 plane 0 not replicated");
endmodule

// ==== sim/pgdp_host_model.sv ====
// Host CPU model issuing I/O and display-memory cycles
`timescale 1ns/1ps
module pgdp_host_model (
	input wire logic clk_sys_i,
	input wire logic [7:0] io_rdata_i,
	input wire logic [7:0] mem_rdata_i,
	input wire logic mem_rvalid_i,
	output logic io_wr_o,
	output logic io_rd_o,
	output logic [15:0] io_addr_o,
	output logic [7:0] io_wdata_o,
	output logic mem_wr_o,
	output logic mem_rd_o,
	output logic [19:0] mem_addr_o,
	output logic [7:0] mem_wdata_o
);
	initial begin
		io_wr_o = 1'b0;
		io_rd_o = 1'b0;
		io_addr_o = 16'h0000;
		io_wdata_o = 8'h00;
		mem_wr_o = 1'b0;
		mem_rd_o = 1'b0;
		mem_addr_o = 20'h00000;
		mem_wdata_o = 8'h00;
	end
	////////////////////////////////////////////////////////////////////
	// One-cycle strobes; released lines show the inverse value
	task automatic io_cyc(input logic wr, input logic [15:0] a,
		input logic [7:0] d, output logic [7:0] q);
		@(posedge clk_sys_i);
		#1;
		io_wr_o = wr;
		io_rd_o = ~wr;
		io_addr_o = a;
		io_wdata_o = d;
		@(posedge clk_sys_i);
		#1;
		q = io_rdata_i;
		io_wr_o = 1'b0;
		io_rd_o = 1'b0;
		io_addr_o = ~a;
		io_wdata_o = ~d;
	endtask
	// Reads wait for the valid pulse, which also keeps read spacing
	task automatic mem_cyc(input logic wr, input logic [19:0] a,
		input logic [7:0] d, output logic [7:0] q);
		@(posedge clk_sys_i);
		#1;
		mem_wr_o = wr;
		mem_rd_o = ~wr;
		mem_addr_o = a;
		mem_wdata_o = d;
		@(posedge clk_sys_i);
		#1;
		mem_wr_o = 1'b0;
		mem_rd_o = 1'b0;
		mem_addr_o = ~a;
		mem_wdata_o = ~d;
		for (int i = 0; i < 4 && !wr && !mem_rvalid_i; i++) begin
			@(posedge clk_sys_i);
			#1;
		end
		q = mem_rdata_i;
	endtask
	task automatic set_addr(input logic [19:0] a);
		@(posedge clk_sys_i);
		#1;
		mem_addr_o = a;
	endtask
	task automatic set_io(input logic [15:0] a);
		@(posedge clk_sys_i);
		#1;
		io_addr_o = a;
	endtask
endmodule

// ==== sim/pgdp_top_tb.sv ====
// Self-checking testbench for the planar graphics datapath
`timescale 1ns/1ps
module pgdp_top_tb
	import pgdp_pkg::*;
;
	logic clk_sys_i = 1'b0;
	logic rst_i = 1'b1;
	logic io_wr_i, io_rd_i, mem_wr_i, mem_rd_i, io_hit_o, mem_hit_o;
	logic [15:0] io_addr_i, plane_addr_o, la;
	logic [7:0] io_wdata_i, io_rdata_o, mem_wdata_i, mem_rdata_o, q;
	logic mem_rvalid_o, shift_256_o, graphics_mode_o, char_latch_en_o;
	logic shift_interleave_o;
	logic [19:0] mem_addr_i;
	logic [3:0] plane_write_mask_i = 4'hF;
	logic [7:0] memory_organization_i = 8'h06;
	logic [3:0] plane_we_o, plane_re_o, wel;
	logic [3:0][7:0] plane_wdata_o;
	logic [3:0][7:0] plane_rdata_i = 32'h00000000;
	logic [7:0] pm [0:3][0:65535];
	logic [31:0] tbl [0:3];
	int n_mismatch = 0;
	int check_count = 0;
	int cyc = 0;
	always #4 clk_sys_i = ~clk_sys_i;
	pgdp_top pgdp_top_i (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
		.io_wr_i(io_wr_i), .io_rd_i(io_rd_i), .io_addr_i(io_addr_i),
		.io_wdata_i(io_wdata_i), .io_rdata_o(io_rdata_o),
		.io_hit_o(io_hit_o), .mem_wr_i(mem_wr_i), .mem_rd_i(mem_rd_i),
		.mem_addr_i(mem_addr_i), .mem_wdata_i(mem_wdata_i),
		.mem_rdata_o(mem_rdata_o), .mem_hit_o(mem_hit_o),
		.mem_rvalid_o(mem_rvalid_o),
		.plane_write_mask_i(plane_write_mask_i),
		.memory_organization_i(memory_organization_i),
		.plane_addr_o(plane_addr_o), .plane_we_o(plane_we_o),
		.plane_re_o(plane_re_o), .plane_wdata_o(plane_wdata_o),
		.plane_rdata_i(plane_rdata_i), .shift_256_o(shift_256_o),
		.shift_interleave_o(shift_interleave_o),
		.graphics_mode_o(graphics_mode_o),
		.char_latch_en_o(char_latch_en_o));
	pgdp_host_model pgdp_host_model_i (.clk_sys_i(clk_sys_i),
		.io_rdata_i(io_rdata_o), .mem_rdata_i(mem_rdata_o),
		.mem_rvalid_i(mem_rvalid_o), .io_wr_o(io_wr_i), .io_rd_o(io_rd_i),
		.io_addr_o(io_addr_i), .io_wdata_o(io_wdata_i),
		.mem_wr_o(mem_wr_i), .mem_rd_o(mem_rd_i),
		.mem_addr_o(mem_addr_i), .mem_wdata_o(mem_wdata_i));
	////////////////////////////////////////////////////////////////////
	// Plane memory; idle read data toggles every cycle
	always @(posedge clk_sys_i) begin
		for (int p = 0; p < 4; p++) begin
			if (plane_we_o[p]) begin
				pm[p][plane_addr_o] <= plane_wdata_o[p];
			end
			plane_rdata_i[p] <= plane_re_o[p] ? pm[p][plane_addr_o] :
				~plane_rdata_i[p];
		end
		if (|plane_we_o) begin
			la <= plane_addr_o;
			wel <= plane_we_o;
		end
	end
	always @(posedge clk_sys_i) begin
		cyc++;
		if (cyc == 20000) begin
			n_mismatch++;
			$display("MISMATCH t=%0t timeout", $time);
			print_verdict();
		end
	end
	////////////////////////////////////////////////////////////////////
	task automatic print_verdict();
		if (n_mismatch == 0 && check_count > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		check_count++;
		if (got !== exp) begin
			n_mismatch++;
			$display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic gw(input logic [3:0] i, input logic [7:0] v);
		pgdp_host_model_i.io_cyc(1'b1, PGDP_PORT_INDEX, {4'h0, i}, q);
		pgdp_host_model_i.io_cyc(1'b1, PGDP_PORT_DATA, v, q);
	endtask
	task automatic gr(input logic [3:0] i, input logic [7:0] e);
		pgdp_host_model_i.io_cyc(1'b1, PGDP_PORT_INDEX, {4'h0, i}, q);
		pgdp_host_model_i.io_cyc(1'b0, PGDP_PORT_DATA, 8'h00, q);
		chk(q, e);
	endtask
	task automatic mw(input logic [19:0] a, input logic [7:0] d);
		pgdp_host_model_i.mem_cyc(1'b1, a, d, q);
	endtask
	task automatic mr(input logic [19:0] a, input logic [7:0] e);
		pgdp_host_model_i.mem_cyc(1'b0, a, 8'h00, q);
		chk(q, e);
	endtask
	task automatic pl(input logic [31:0] e);
		for (int p = 0; p < 4; p++) begin
			chk(pm[p][la], e[p*8 +: 8]);
		end
	endtask
	////////////////////////////////////////////////////////////////////
	task automatic t_regs();
		gr(4'h5, 8'h00);
		gr(4'h8, 8'hFF);
		gr(4'h7, 8'h0F);
		gw(4'h3, 8'h1B);
		gr(4'h3, 8'h1B);
		gw(4'h3, 8'h00);
		pgdp_host_model_i.io_cyc(1'b0, PGDP_PORT_INDEX, 8'h00, q);
		chk(q, 8'h03);
		gw(4'h9, 8'hFF);
		gr(4'h9, 8'h00);
	endtask
	task automatic t_read();
		gw(4'h5, 8'h02);
		mw(20'hA0002, 8'h09);
		pl(32'hFF0000FF);
		gw(4'h5, 8'h00);
		for (int p = 0; p < 4; p++) begin
			gw(4'h4, p[7:0]);
			mr(20'hA0002, tbl[0][p*8 +: 8]);
		end
		gw(4'h5, 8'h08);
		gw(4'h2, 8'h09);
		mr(20'hA0002, 8'hFF);
		gw(4'h2, 8'h01);
		mr(20'hA0002, 8'h00);
		gw(4'h7, 8'h07);
		mr(20'hA0002, 8'hFF);
		gw(4'h7, 8'h0F);
		gw(4'h5, 8'h00);
	endtask
	task automatic t_write();
		for (int f = 0; f < 4; f++) begin
			gw(4'h3, {3'b000, f[1:0], 3'b000});
			mw(20'hA0003, 8'h3C);
			pl(tbl[f]);
		end
		gw(4'h3, 8'h00);
		gw(4'h5, 8'h01);
		mw(20'hA0004, 8'hAA);
		pl(32'hFF0000FF);
		gw(4'h5, 8'h03);
		gw(4'h0, 8'h0A);
		gw(4'h8, 8'h0F);
		mw(20'hA0005, 8'h3C);
		pl(32'hFF000CF3);
		gw(4'h5, 8'h00);
		gw(4'h0, 8'h00);
		gw(4'h8, 8'hF0);
		mw(20'hA0006, 8'h55);
		pl(32'h5F50505F);
		gw(4'h8, 8'hFF);
		plane_write_mask_i = 4'h5;
		mw(20'hA0007, 8'h77);
		chk({4'h0, wel}, 8'h05);
		plane_write_mask_i = 4'hF;
		gw(4'h3, 8'h03);
		mw(20'hA0008, 8'hCA);
		pl(32'h59595959);
		gw(4'h3, 8'h00);
		gw(4'h0, 8'h04);
		gw(4'h1, 8'h05);
		mw(20'hA0009, 8'hCD);
		pl(32'hCDFFCD00);
		gw(4'h1, 8'h00);
	endtask
	task automatic t_addr();
		memory_organization_i = 8'h0E;
		mw(20'hA0011, 8'h5A);
		chk({4'h0, wel}, 8'h02);
		chk(la[7:0], 8'h04);
		mr(20'hA0011, 8'h5A);
		memory_organization_i = 8'h06;
		gw(4'h6, 8'h02);
		mw(20'hB0005, 8'h3C);
		chk({4'h0, wel}, 8'h0A);
		chk(la[15:8], 8'h00);
		chk(la[7:0], 8'h05);
		gw(4'h6, 8'h00);
		gw(4'h5, 8'h10);
		mw(20'hA0007, 8'h3C);
		chk({4'h0, wel}, 8'h0A);
		chk(la[7:0], 8'h03);
		gw(4'h5, 8'h00);
		memory_organization_i = 8'h02;
		mw(20'hA0006, 8'h3C);
		chk({4'h0, wel}, 8'h05);
		chk(la[7:0], 8'h03);
		memory_organization_i = 8'h06;
	endtask
	task automatic t_misc();
		logic [19:0] ad [0:3];
		ad = '{20'hA0000, 20'hB0000, 20'hB8000, 20'hC0000};
		for (int m = 0; m < 4; m++) begin
			gw(4'h6, {4'h0, m[1:0], 2'b00});
			for (int k = 0; k < 4; k++) begin
				pgdp_host_model_i.set_addr(ad[k]);
				#1;
				chk({7'h00, mem_hit_o}, {7'h00, tbl[1][31-m*4-k]});
			end
		end
		gw(4'h6, 8'h01);
		chk({6'h00, graphics_mode_o, char_latch_en_o}, 8'h02);
		gw(4'h5, 8'h40);
		chk({6'h00, shift_256_o, shift_interleave_o}, 8'h02);
		gw(4'h5, 8'h20);
		chk({6'h00, shift_256_o, shift_interleave_o}, 8'h01);
		gw(4'h5, 8'h60);
		chk({6'h00, shift_256_o, shift_interleave_o}, 8'h02);
		gw(4'h5, 8'h00);
		pgdp_host_model_i.set_io(PGDP_PORT_DATA);
		#1;
		chk({7'h00, io_hit_o}, 8'h01);
		pgdp_host_model_i.set_io(16'h03CD);
		#1;
		chk({7'h00, io_hit_o}, 8'h00);
	endtask
	////////////////////////////////////////////////////////////////////
	initial begin
		tbl[0] = 32'hFF0000FF;
		tbl[1] = 32'hE8420000;
		repeat (20) @(posedge clk_sys_i);
		#1;
		rst_i = 1'b0;
		t_regs();
		t_read();
		tbl = '{32'h3C3C3C3C, 32'h3C00003C, 32'hFF3C3CFF, 32'hC33C3CC3};
		t_write();
		t_addr();
		tbl[1] = 32'hE8420000;
		t_misc();
		print_verdict();
	end
endmodule
